//--- core/dps_defines.svh
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH

// sample word width
`define DPS_WORD_W 14
// all-ones code, full scale on the true output
`define DPS_FULL_SCALE 14'h3fff
// zero code
`define DPS_ZERO_CODE 14'h0000
// reset value of the captured word
`define DPS_WORD_RST 14'h0000
// update rate limit in samples per microsecond, kept as a figure
`define DPS_MAX_RATE_MSPS 125
// sample word bit that carries the weight of the code's top bit
`define DPS_MSB 13
// reset level of the power-down synchroniser stages
`define DPS_PIN_RST 1'h0

`endif

//--- core/dps_pkg.sv
package dps_pkg;
    // power state of the converter output
    typedef enum logic [1:0] {
        DPS_ACTIVE = 2'h1,
        DPS_STANDBY = 2'h2
    } dps_pwr_t;
endpackage : dps_pkg

//--- core/dps_word_if.sv
`timescale 1ns/100ps
`include "dps_defines.svh"
interface dps_word_if;
    logic [`DPS_WORD_W-1:0] word;
    logic enable;
    modport src (output word, output enable);
    modport dst (input word, input enable);
endinterface : dps_word_if

//--- core/dps_split.sv
`timescale 1ns/100ps
`include "dps_defines.svh"
module dps_split (
    // registered word and power state
    dps_word_if.dst word_port,
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // code weights for the two current outputs
    output logic [`DPS_WORD_W-1:0] true_current_output_out,
    output logic [`DPS_WORD_W-1:0] complement_current_output_out
);
    logic [`DPS_WORD_W-1:0] true_reg, true_next;
    logic [`DPS_WORD_W-1:0] comp_reg, comp_next;

    // split full scale between outputs, zero both in standby
    always_comb begin
        if (word_port.enable) begin
            true_next = word_port.word;
            comp_next = `DPS_FULL_SCALE - word_port.word;
        end else begin
            true_next = `DPS_ZERO_CODE;
            comp_next = `DPS_ZERO_CODE;
        end
    end

    // output register
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            true_reg <= `DPS_ZERO_CODE;
            comp_reg <= `DPS_ZERO_CODE;
        end else begin
            true_reg <= true_next;
            comp_reg <= comp_next;
        end
    end

    assign true_current_output_out = true_reg;
    assign complement_current_output_out = comp_reg;
endmodule : dps_split

//--- core/dps_top.sv
// Operation
// - 14-bit unsigned straight binary, top bit MSB
// - all ones gives full scale on true output
// - capture word on rising clock edge
// - power-down pulled inactive when left open
// - power-down high stops current, enters standby
`timescale 1ns/100ps
`include "dps_defines.svh"
module dps_top (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // sample word from the source, same clock domain
    input wire logic [`DPS_WORD_W-1:0] sample_word_bits_in,
    // power-down pin, asynchronous to the clock
    input wire logic power_down_in,
    input wire logic power_down_driven_in,
    // converter drive
    output logic [`DPS_WORD_W-1:0] true_current_output_out,
    output logic [`DPS_WORD_W-1:0] complement_current_output_out,
    output logic standby_out
);
    ////////////////////////////////////////////////////////////////
    logic [`DPS_WORD_W-1:0] word_reg, word_next;
    logic pd_meta_reg, pd_meta_next;
    logic pd_sync_reg, pd_sync_next;
    logic drv_meta_reg, drv_meta_next;
    logic drv_sync_reg, drv_sync_next;
    dps_pkg::dps_pwr_t pwr_reg, pwr_next;
    logic pd_pin;
    dps_word_if word_bus ();

    // undriven pin reads low, as the internal pull-down holds it
    assign pd_pin = drv_sync_reg & pd_sync_reg;

    ////////////////////////////////////////////////////////////////
    // capture stage, data held until the next rising edge
    always_comb begin
        word_next = sample_word_bits_in;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            word_reg <= `DPS_WORD_RST;
        end else begin
            word_reg <= word_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // two-stage synchronisers for the power-down pin and its drive flag
    always_comb begin
        pd_meta_next = power_down_in;
        pd_sync_next = pd_meta_reg;
        drv_meta_next = power_down_driven_in;
        drv_sync_next = drv_meta_reg;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pd_meta_reg <= `DPS_PIN_RST;
            pd_sync_reg <= `DPS_PIN_RST;
            drv_meta_reg <= `DPS_PIN_RST;
            drv_sync_reg <= `DPS_PIN_RST;
        end else begin
            pd_meta_reg <= pd_meta_next;
            pd_sync_reg <= pd_sync_next;
            drv_meta_reg <= drv_meta_next;
            drv_sync_reg <= drv_sync_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // power state machine
    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            dps_pkg::DPS_ACTIVE: begin
                if (pd_pin) begin
                    pwr_next = dps_pkg::DPS_STANDBY;
                end
            end
            dps_pkg::DPS_STANDBY: begin
                if (!pd_pin) begin
                    pwr_next = dps_pkg::DPS_ACTIVE;
                end
            end
            default: begin
                pwr_next = dps_pkg::DPS_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwr_reg <= dps_pkg::DPS_ACTIVE;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // hand the held word to the output stage
    assign word_bus.word = word_reg;
    assign word_bus.enable = (pwr_reg == dps_pkg::DPS_ACTIVE);
    assign standby_out = (pwr_reg == dps_pkg::DPS_STANDBY);

    dps_split dps_split_i (
        .word_port(word_bus.dst),
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .true_current_output_out(true_current_output_out),
        .complement_current_output_out(complement_current_output_out)
    );
endmodule : dps_top

//--- tb/dps_src_model.sv
`timescale 1ns/100ps
module dps_src_model (
    input wire logic mclk_in,
    input wire logic [13:0] next_in,
    output logic [13:0] word_out = 14'h0000
);
    // launch each word on the falling edge, one per clock
    always @(negedge mclk_in) word_out <= next_in;
endmodule : dps_src_model

//--- tb/dps_top_chk.sv
`timescale 1ns/100ps
module dps_top_chk (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // power-down pin and its drive flag
    input wire logic power_down_in,
    input wire logic power_down_driven_in,
    // sample word and converter drive
    input wire logic [13:0] sample_word_bits_in,
    input wire logic [13:0] true_current_output_out,
    input wire logic [13:0] complement_current_output_out,
    input wire logic standby_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // awake: word two edges late, complement fills the rest
    sequence live; !$past(standby_out) && $past(rst_n_in, 2); endsequence
    // pin driven high for four edges
    sequence pd_held; (power_down_in && power_down_driven_in) [*4]; endsequence
    // pin low or left open for four edges
    sequence pd_clear; (!(power_down_in && power_down_driven_in)) [*4]; endsequence
    chk_word_path: assert property (live |->
        true_current_output_out == $past(sample_word_bits_in, 2) &&
        complement_current_output_out == 14'h3fff - true_current_output_out) else $error("word");
    chk_sleep_on: assert property (pd_held |=>
        standby_out) else $error("on");
    chk_wake_off: assert property (pd_clear |=>
        !standby_out) else $error("standby without a driven power-down level");
    chk_sleep_zero: assert property ($past(standby_out) |->
        true_current_output_out == 14'h0000 && complement_current_output_out == 14'h0000)
        else $error("current flows in standby");
    chk_rise_cause: assert property ($rose(standby_out) |->
        $past(power_down_in, 3) && $past(power_down_driven_in, 3))
        else $error("standby entered without power-down");
    chk_fall_cause: assert property ($fell(standby_out) |->
        !($past(power_down_in, 3) && $past(power_down_driven_in, 3)))
        else $error("standby left while power-down held");
endmodule : dps_top_chk
bind dps_top dps_top_chk dps_top_chk_i (.*);

//--- tb/dac_parallel_sample_input_test.sv
`timescale 1ns/100ps
module dac_parallel_sample_input_test;
    logic mclk_in = 1'h0, rst_n_in = 1'h0, pd = 1'h0, drv = 1'h1, sb;
    logic [13:0] nxt = 14'h0000, word, tru, cmp;
    int mismatches = 0, total_checks = 0;
    // 200 MHz clock
    initial forever #2.5 mclk_in = ~mclk_in;
    dps_src_model dps_src_model_i (.mclk_in, .next_in(nxt), .word_out(word));
    dps_top dps_top_i (.mclk_in, .rst_n_in, .sample_word_bits_in(word), .power_down_in(pd),
        .power_down_driven_in(drv), .true_current_output_out(tru),
        .complement_current_output_out(cmp), .standby_out(sb));
    task cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : cyc
    task chk(input logic [13:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t bad value %h", $time, got);
        end
    endtask : chk
    task results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    task t_stream;
        for (int i = 0; i < 6; i++) begin
            nxt = 14'h3fff >> i;
            if (i > 1) chk(tru, 14'h3fff >> (i - 2));
            if (i > 1) chk(cmp, 14'h3fff - (14'h3fff >> (i - 2)));
            cyc(1);
        end
        $display("stream end");
    endtask : t_stream
    task t_sleep;
        pd = 1'b1;
        cyc(4);
        chk({13'h0000, sb}, 14'h0001);
        cyc(1);
        chk(tru, 14'h0000);
        chk(cmp, 14'h0000);
        $display("sleep end");
    endtask : t_sleep
    task t_wake;
        pd = 1'h0;
        nxt = 14'h2a55;
        cyc(3);
        chk({13'h0000, sb}, 14'h0000);
        chk(tru, 14'h0000);
        cyc(1);
        chk(tru, 14'h2a55);
        chk(cmp, 14'h3fff - 14'h2a55);
        $display("wake end");
    endtask : t_wake
    task t_open_pin;
        drv = 1'h0;
        pd = 1'h1;
        nxt = 14'h1234;
        cyc(6);
        chk({13'h0000, sb}, 14'h0000);
        chk(tru, 14'h1234);
        chk(cmp, 14'h3fff - 14'h1234);
        drv = 1'h1;
        pd = 1'h0;
        cyc(1);
        $display("open pin end");
    endtask : t_open_pin
    task t_reset;
        rst_n_in = 1'h0;
        nxt = 14'h0abc;
        cyc(1);
        chk(tru, 14'h0000);
        chk(cmp, 14'h0000);
        chk({13'h0000, sb}, 14'h0000);
        cyc(2);
        rst_n_in = 1'h1;
        cyc(1);
        chk(tru, 14'h0000);
        cyc(1);
        chk(tru, 14'h0abc);
        chk(cmp, 14'h3fff - 14'h0abc);
        $display("reset end");
    endtask : t_reset
    initial begin
        cyc(20);
        rst_n_in = 1'b1;
        cyc(1);
        t_stream;
        t_sleep;
        t_wake;
        t_open_pin;
        t_reset;
        results;
    end
endmodule : dac_parallel_sample_input_test
